// ---- hw/hsd_fault_mux.sv ----
// Top of the switch fault and sense logic: APB registers, two channels, sense mux.
// Assumes an APB master on the core clock and asynchronous sensor and comparator pins.
// Overview of operation
// - Reverse battery forces both switches on
// - Protections ignored during reverse battery
// - Latched current-limit fault holds until latch low
// - Latch low: auto retry after clear and interval
// - Retry shows fault until output rises or enable drops
// - Grounded output keeps fault indication while enabled
// - Enabled channel never raises open-load fault
// - Off-state comparator armed by diag, enable low
// - Off-state fault follows comparator continuously
// - Diag fall or enable rise clears off-state fault
// - Fault shown only for selected channel
// - Select inputs pick load current or temperature
// - Load sense is output current over ratio
// - Temperature sense is slope times rise plus offset
// - Fault replaces load measurement with fixed level
// - Thermal, current-limit and open-load are reported
// - Temperature mode reports the hotter channel
// - Diag low floats sense; code 11 unused
// - Fault exit needs clear, latch low, timer
// - Channels keep fully independent state
`timescale 1ns/10ps
module hsd_fault_mux (
  // Clock and reset
  input  wire logic              i_core_clk,
  input  wire logic              i_rstn,
  // APB slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [7:0]        i_paddr,
  input  wire logic [31:0]       i_pwdata,
  input  wire logic [3:0]        i_pstrb,
  output logic [31:0]            o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  // Sensor and comparator pins
  input  wire hsd_pkg::pins_t    i_pins,
  // Switch drive
  output logic [1:0]             o_sw_on,
  // Sense output
  output logic                   o_sense_oe,
  output hsd_pkg::sense_mode_t   o_sense_mode,
  output logic [15:0]            o_sense_val
);

  // ==========================================================================
  // Declarations
  hsd_pkg::top_reg_t    q;
  hsd_pkg::top_reg_t    d;
  hsd_pkg::pins_t       pins_s;
  hsd_pkg::chan_in_t    ch_in [2];
  hsd_pkg::chan_st_t    ch_st [2];
  logic [1:0]           ch_sw;
  logic [1:0]           ch_flt;
  logic                 setup;
  logic                 wr_go;
  logic                 hit;
  logic                 ro;
  logic [1:0]           pick;
  logic                 pch;
  logic signed [8:0]    hot;
  logic [32:0]          load_prod;
  int                   tv;
  logic [31:0]          rdat;

  // ==========================================================================
  // Pin synchroniser
  hsd_pin_sync u_sync (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_pins     (i_pins),
    .o_pins     (pins_s)
  );

  // ==========================================================================
  // Channels, each fully independent of the other
  for (genvar c = 0; c < 2; c++) begin : g_ch
    // Per-channel inputs gathered from control bits and synced pins
    always_comb begin
      ch_in[c].en      = q.ctrl[hsd_pkg::CTRL_ON1 + c];
      ch_in[c].diag    = q.ctrl[hsd_pkg::CTRL_DIAG];
      ch_in[c].latch   = q.ctrl[hsd_pkg::CTRL_LATCH];
      ch_in[c].rev     = pins_s.rev_batt;
      ch_in[c].tsd     = pins_s.tsd[c];
      ch_in[c].ilim    = pins_s.ilim[c];
      ch_in[c].vout_up = pins_s.vout_up[c];
      ch_in[c].vout_ol = pins_s.vout_ol[c];
      ch_in[c].retry   = q.retry;
    end

    hsd_chan u_chan (
      .i_core_clk (i_core_clk),
      .i_rstn     (i_rstn),
      .i_ch       (ch_in[c]),
      .o_sw_on    (ch_sw[c]),
      .o_fault    (ch_flt[c]),
      .o_state    (ch_st[c])
    );
  end

  // ==========================================================================
  // APB decode: data is prepared in the setup cycle so the answer is a flop
  always_comb begin
    setup = i_psel & ~i_penable;
    wr_go = i_psel & i_penable & q.pready & i_pwrite;
    hit   = (i_paddr == hsd_pkg::ADDR_CTRL) | (i_paddr == hsd_pkg::ADDR_STAT)
          | (i_paddr == hsd_pkg::ADDR_RETRY) | (i_paddr == hsd_pkg::ADDR_SENSE);
    ro    = (i_paddr == hsd_pkg::ADDR_STAT) | (i_paddr == hsd_pkg::ADDR_SENSE);
    rdat  = 32'h0000_0000;
    case (i_paddr)
      hsd_pkg::ADDR_CTRL: begin
        rdat[hsd_pkg::CTRL_W-1:0] = q.ctrl;
      end
      hsd_pkg::ADDR_STAT: begin
        rdat[hsd_pkg::STAT_SW +: 2]   = ch_sw;
        rdat[hsd_pkg::STAT_FLT +: 2]  = ch_flt;
        rdat[hsd_pkg::STAT_REV]       = pins_s.rev_batt;
        rdat[hsd_pkg::STAT_MODE +: 2] = q.sense_mode;
      end
      hsd_pkg::ADDR_RETRY: begin
        rdat[15:0] = q.retry;
      end
      hsd_pkg::ADDR_SENSE: begin
        rdat[15:0] = q.sense_val;
      end
      default: begin
        rdat = 32'h0000_0000;
      end
    endcase
  end

  // ==========================================================================
  // Sense transfer functions
  always_comb begin
    tv        = 0;
    pick      = {q.ctrl[hsd_pkg::CTRL_PICK_A], q.ctrl[hsd_pkg::CTRL_PICK_B]};
    // Second select bit routes both current and off-state diagnosis
    pch       = pick[0];
    // Load current in uA is the output current over the sense ratio
    load_prod = 33'(pins_s.iout_ma[pch]) * 33'(hsd_pkg::SENSE_RECIP);
    // Hotter channel wins in temperature mode
    if ($signed(pins_s.tj_c[0]) > $signed(pins_s.tj_c[1])) begin
      hot = 9'($signed(pins_s.tj_c[0]));
    end else begin
      hot = 9'($signed(pins_s.tj_c[1]));
    end
    tv = (int'(hot) - hsd_pkg::TEMP_REF_C) * hsd_pkg::TEMP_SLOPE_UA
       + hsd_pkg::TEMP_OFFS_UA;
    // Clamp: the sense source cannot sink current
    if (tv < 0) begin
      tv = 0;
    end else if (tv > hsd_pkg::SENSE_MAX) begin
      tv = hsd_pkg::SENSE_MAX;
    end
  end

  // ==========================================================================
  // Next register values: bus, then sense mux
  always_comb begin
    d         = q;
    d.pready  = setup & ~q.pready;
    if (setup) begin
      d.prdata  = i_pwrite ? 32'h0000_0000 : rdat;
      d.pslverr = ~hit | (i_pwrite & ro);
    end
    if (wr_go && !q.pslverr) begin
      if (i_paddr == hsd_pkg::ADDR_CTRL && i_pstrb[0]) begin
        d.ctrl = i_pwdata[hsd_pkg::CTRL_W-1:0];
      end
      if (i_paddr == hsd_pkg::ADDR_RETRY) begin
        if (i_pstrb[0]) begin
          d.retry[7:0] = i_pwdata[7:0];
        end
        if (i_pstrb[1]) begin
          d.retry[15:8] = i_pwdata[15:8];
        end
      end
    end
    // Mux: diag low floats the pin, code 11 is not a valid choice
    d.sense_oe   = 1'b0;
    d.sense_mode = hsd_pkg::SENSE_HIZ;
    d.sense_val  = 16'h0000;
    if (q.ctrl[hsd_pkg::CTRL_DIAG]) begin
      case (pick)
        2'b00, 2'b01: begin
          d.sense_oe = 1'b1;
          if (ch_flt[pch]) begin
            d.sense_mode = hsd_pkg::SENSE_FAULT;
            d.sense_val  = hsd_pkg::FAULT_LVL_UA;
          end else begin
            d.sense_mode = hsd_pkg::SENSE_LOAD;
            d.sense_val  = load_prod[31:16];
          end
        end
        2'b10: begin
          d.sense_oe   = 1'b1;
          d.sense_mode = hsd_pkg::SENSE_TEMP;
          d.sense_val  = 16'(tv);
        end
        default: begin
          d.sense_oe   = 1'b0;
        end
      endcase
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '{ctrl: hsd_pkg::CTRL_RST, retry: hsd_pkg::RETRY_RST,
             sense_mode: hsd_pkg::SENSE_HIZ, default: '0};
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Outputs, all straight from flops
  assign o_prdata     = q.prdata;
  assign o_pready     = q.pready;
  assign o_pslverr    = q.pslverr;
  assign o_sw_on      = ch_sw;
  assign o_sense_oe   = q.sense_oe;
  assign o_sense_mode = q.sense_mode;
  assign o_sense_val  = q.sense_val;

  // ==========================================================================
  // Checks
  property p_diag_low_hiz;
    @(posedge i_core_clk) disable iff (!i_rstn)
    !q.ctrl[hsd_pkg::CTRL_DIAG] |=> (!o_sense_oe && o_sense_mode == hsd_pkg::SENSE_HIZ);
  endproperty
  a_diag_low_hiz: assert property (p_diag_low_hiz) else $error("sense not floating");

  property p_fault_routed;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (q.ctrl[hsd_pkg::CTRL_DIAG] && !q.ctrl[hsd_pkg::CTRL_PICK_A])
      |=> (o_sense_mode == hsd_pkg::SENSE_FAULT) == $past(ch_flt[q.ctrl[hsd_pkg::CTRL_PICK_B]]);
  endproperty
  a_fault_routed: assert property (p_fault_routed) else $error("fault not on its channel");

  property p_fault_level;
    @(posedge i_core_clk) disable iff (!i_rstn)
    o_sense_mode == hsd_pkg::SENSE_FAULT |-> o_sense_val == hsd_pkg::FAULT_LVL_UA;
  endproperty
  a_fault_level: assert property (p_fault_level) else $error("fault level wrong");

  property p_temp_mode;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (q.ctrl[hsd_pkg::CTRL_DIAG] && pick == 2'b10) |=> o_sense_mode == hsd_pkg::SENSE_TEMP;
  endproperty
  a_temp_mode: assert property (p_temp_mode) else $error("temperature not selected");

  property p_apb_one_wait;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (i_psel && !i_penable && !q.pready) |=> o_pready ##1 !o_pready;
  endproperty
  a_apb_one_wait: assert property (p_apb_one_wait) else $error("apb answer timing");

  // A faulted channel may drive its switch only when reverse battery forced it on;
  // the drive flop saw the synced reverse flag one cycle earlier, hence the past value
  property p_fault_sw_off;
    @(posedge i_core_clk) disable iff (!i_rstn)
    ((ch_st[0] == hsd_pkg::CH_FAULT && ch_sw[0]) || (ch_st[1] == hsd_pkg::CH_FAULT && ch_sw[1]))
      |-> $past(pins_s.rev_batt);
  endproperty
  a_fault_sw_off: assert property (p_fault_sw_off) else $error("faulted switch still on");

  c_sense_fault: cover property (@(posedge i_core_clk) o_sense_mode == hsd_pkg::SENSE_FAULT);
  c_sense_temp:  cover property (@(posedge i_core_clk) o_sense_mode == hsd_pkg::SENSE_TEMP);

endmodule

// ---- hw/hsd_pkg.sv ----
// Shared constants and carrier types for the dual-channel high-side switch fault logic.
// Assumes a single 125 MHz core clock; every pin-side input is asynchronous to it.
package hsd_pkg;

  // ==========================================================================
  // Register map (byte addresses on APB)
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_STAT   = 8'h04;
  localparam logic [7:0]  ADDR_RETRY  = 8'h08;
  localparam logic [7:0]  ADDR_SENSE  = 8'h0c;

  // Control register field positions and reset value
  localparam int          CTRL_ON1    = 0;
  localparam int          CTRL_ON2    = 1;
  localparam int          CTRL_DIAG   = 2;
  localparam int          CTRL_LATCH  = 3;
  localparam int          CTRL_PICK_A = 4;
  localparam int          CTRL_PICK_B = 5;
  localparam int          CTRL_W      = 6;
  localparam logic [5:0]  CTRL_RST    = 6'h00;

  // Status register field positions
  localparam int          STAT_SW     = 0;
  localparam int          STAT_FLT    = 2;
  localparam int          STAT_REV    = 4;
  localparam int          STAT_MODE   = 5;

  // Retry interval in core clock cycles (8 us at 125 MHz by default)
  localparam logic [15:0] RETRY_RST   = 16'h03e8;

  // ==========================================================================
  // Sense transfer constants; sense values are in microamps
  localparam int          SENSE_RATIO   = 1500;
  localparam int          UA_PER_MA     = 1000;
  localparam logic [16:0] SENSE_RECIP   = 17'((65536 * UA_PER_MA) / SENSE_RATIO);
  localparam int          TEMP_REF_C    = 25;
  localparam int          TEMP_SLOPE_UA = 10;
  localparam int          TEMP_OFFS_UA  = 850;
  localparam logic [15:0] FAULT_LVL_UA  = 16'h1f40;
  localparam int          SENSE_MAX     = 65535;

  // ==========================================================================
  // Enumerations
  typedef enum logic [2:0] {
    CH_RUN   = 3'b001,
    CH_FAULT = 3'b010,
    CH_RETRY = 3'b100
  } chan_st_t;

  typedef enum logic [1:0] {
    SENSE_HIZ   = 2'h0,
    SENSE_LOAD  = 2'h1,
    SENSE_TEMP  = 2'h2,
    SENSE_FAULT = 2'h3
  } sense_mode_t;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic              rev_batt;
    logic [1:0]        tsd;
    logic [1:0]        ilim;
    logic [1:0]        vout_up;
    logic [1:0]        vout_ol;
    logic [1:0][15:0]  iout_ma;
    logic [1:0][7:0]   tj_c;
  } pins_t;

  typedef struct packed {
    pins_t s1;
    pins_t s2;
  } sync_reg_t;

  typedef struct packed {
    logic        en;
    logic        diag;
    logic        latch;
    logic        rev;
    logic        tsd;
    logic        ilim;
    logic        vout_up;
    logic        vout_ol;
    logic [15:0] retry;
  } chan_in_t;

  typedef struct packed {
    chan_st_t    st;
    logic [15:0] cnt;
    logic        en_q;
    logic        diag_q;
    logic        offdiag;
    logic        sw_on;
    logic        fault;
  } chan_reg_t;

  typedef struct packed {
    logic [5:0]  ctrl;
    logic [15:0] retry;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sense_oe;
    sense_mode_t sense_mode;
    logic [15:0] sense_val;
  } top_reg_t;

endpackage

// ---- hw/hsd_pin_sync.sv ----
// Two-stage synchroniser for every pin-side input of the switch.
// Assumes multi-bit analog readings change slowly against the core clock.
`timescale 1ns/10ps
module hsd_pin_sync (
  // Clock and reset
  input  wire logic          i_core_clk,
  input  wire logic          i_rstn,
  // Pins in, synchronised copy out
  input  wire hsd_pkg::pins_t i_pins,
  output hsd_pkg::pins_t      o_pins
);

  hsd_pkg::sync_reg_t q;
  hsd_pkg::sync_reg_t d;

  // ==========================================================================
  // First stage feeds only the second stage
  always_comb begin
    d    = q;
    d.s1 = i_pins;
    d.s2 = q.s1;
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_pins = q.s2;

endmodule

// ---- hw/hsd_chan.sv ----
// One switch channel: fault state, retry timer, off-state diagnosis, gate drive.
// Assumes all inputs are already on the core clock; channels share nothing.
`timescale 1ns/10ps
module hsd_chan (
  // Clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_rstn,
  // Channel controls and sensors
  input  wire hsd_pkg::chan_in_t i_ch,
  // Channel results
  output logic                  o_sw_on,
  output logic                  o_fault,
  output hsd_pkg::chan_st_t     o_state
);

  hsd_pkg::chan_reg_t q;
  hsd_pkg::chan_reg_t d;
  logic               flt;

  // ==========================================================================
  // Next-state logic
  always_comb begin
    d      = q;
    d.en_q   = i_ch.en;
    d.diag_q = i_ch.diag;
    // Protections are blind under reverse battery
    flt    = ~i_ch.rev & (i_ch.tsd | i_ch.ilim);
    case (q.st)
      hsd_pkg::CH_RUN: begin
        if (flt && q.sw_on) begin
          d.st  = hsd_pkg::CH_FAULT;
          d.cnt = i_ch.retry;
        end
      end
      hsd_pkg::CH_FAULT: begin
        if (q.cnt != 16'h0000) begin
          d.cnt = q.cnt - 16'h0001;
        end
        // Latch high parks the channel here regardless of the timer
        if (!flt && !i_ch.latch && q.cnt == 16'h0000) begin
          d.st = i_ch.en ? hsd_pkg::CH_RETRY : hsd_pkg::CH_RUN;
        end
      end
      hsd_pkg::CH_RETRY: begin
        // No timeout: a grounded output keeps the indication for as long as enable stays high
        if (flt) begin
          d.st  = hsd_pkg::CH_FAULT;
          d.cnt = i_ch.retry;
        end else if (i_ch.vout_up || !i_ch.en) begin
          d.st = hsd_pkg::CH_RUN;
        end
      end
      default: begin
        d.st = hsd_pkg::CH_RUN;
      end
    endcase
    // Reverse battery forces the switch on to spare the body diode
    d.sw_on   = i_ch.rev | (i_ch.en & (d.st != hsd_pkg::CH_FAULT));
    // Comparator follows the output, armed only with diag high and enable low
    d.offdiag = i_ch.diag & ~i_ch.en & i_ch.vout_ol
              & ~(q.diag_q & ~i_ch.diag) & ~(~q.en_q & i_ch.en);
    d.fault   = (d.st != hsd_pkg::CH_RUN) | d.offdiag;
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '{st: hsd_pkg::CH_RUN, default: '0};
    end else begin
      q <= d;
    end
  end

  assign o_sw_on = q.sw_on;
  assign o_fault = q.fault;
  assign o_state = q.st;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  property p_rev_forces_on;
    i_ch.rev |=> q.sw_on;
  endproperty
  a_rev_forces_on: assert property (p_rev_forces_on) else $error("reverse battery not on");

  property p_rev_no_trip;
    (i_ch.rev && q.st == hsd_pkg::CH_RUN) |=> q.st == hsd_pkg::CH_RUN;
  endproperty
  a_rev_no_trip: assert property (p_rev_no_trip) else $error("fault taken in reverse");

  // Reverse battery legally forces a parked switch on, so it is left out here
  property p_latch_holds;
    (q.st == hsd_pkg::CH_FAULT && i_ch.latch && !i_ch.rev)
      |=> (q.st == hsd_pkg::CH_FAULT && !q.sw_on);
  endproperty
  a_latch_holds: assert property (p_latch_holds) else $error("latched channel left fault");

  property p_auto_retry;
    (q.st == hsd_pkg::CH_FAULT && q.cnt == 16'h0000 && !flt && !i_ch.latch && i_ch.en)
      |=> (q.st == hsd_pkg::CH_RETRY && q.fault) ##1 (q.sw_on || q.st != hsd_pkg::CH_RETRY);
  endproperty
  a_auto_retry: assert property (p_auto_retry) else $error("retry not taken");

  // A zero retry interval legally leaves the fault state after one cycle
  property p_retry_timer;
    (q.st == hsd_pkg::CH_RUN && flt && q.sw_on && i_ch.retry != 16'h0000)
      |=> (q.st == hsd_pkg::CH_FAULT)[*2];
  endproperty
  a_retry_timer: assert property (p_retry_timer) else $error("retry timer skipped");

  property p_retry_indication;
    (q.st == hsd_pkg::CH_RETRY && !i_ch.vout_up && !flt && i_ch.en) |=> q.fault;
  endproperty
  a_retry_indication: assert property (p_retry_indication)
    else $error("fault cleared early");

  property p_on_no_offdiag;
    i_ch.en |=> !q.offdiag;
  endproperty
  a_on_no_offdiag: assert property (p_on_no_offdiag) else $error("open load while on");

  property p_offdiag_follow;
    (i_ch.diag && !i_ch.en && q.diag_q && !q.en_q) |=> (q.offdiag == $past(i_ch.vout_ol));
  endproperty
  a_offdiag_follow: assert property (p_offdiag_follow)
    else $error("comparator not followed");

  property p_diag_fall_clear;
    $fell(i_ch.diag) |=> !q.offdiag;
  endproperty
  a_diag_fall_clear: assert property (p_diag_fall_clear) else $error("diag fall no clear");

  c_fault_seen:  cover property (q.st == hsd_pkg::CH_FAULT);
  c_retry_done:  cover property (q.st == hsd_pkg::CH_RETRY ##1 q.st == hsd_pkg::CH_RUN);
  c_offdiag_hit: cover property (q.offdiag);

endmodule

// ---- bench/host_adc.sv ----
// Host side model: an ADC reading the sense line across a resistor to ground.
// Assumes sense values in microamps and a sense line that reads 0 while undriven.
`timescale 1ns/10ps
module host_adc (
  // Clock and sense line
  input  wire logic                 i_core_clk,
  input  wire logic                 i_sense_oe,
  input  wire hsd_pkg::sense_mode_t i_sense_mode,
  input  wire logic [15:0]          i_sense_val,
  // Sampled reading
  output logic [15:0]               o_adc,
  output hsd_pkg::sense_mode_t      o_mode
);
  // ==========================================================================
  // Sampling
  // A floating line is pulled to ground by the sense resistor, so it reads 0
  always_ff @(posedge i_core_clk) begin
    o_adc  <= i_sense_oe ? i_sense_val : 16'h0000;
    o_mode <= i_sense_oe ? i_sense_mode : hsd_pkg::SENSE_HIZ;
  end
endmodule

// ---- bench/tb.sv ----
// Self-checking bench for the switch fault and sense logic.
// Assumes APB answers within 20 cycles and pins settle through sync in 8 cycles.
`timescale 1ns/10ps
module tb;
  // ==========================================================================
  // Signals
  logic                 i_core_clk  = 1'b0;
  logic                 i_rstn      = 1'b0;
  logic                 psel        = 1'b0;
  logic                 penable     = 1'b0;
  logic                 pwrite      = 1'b0;
  logic [7:0]           paddr       = 8'h00;
  logic [31:0]          pwdata      = 32'h0;
  logic [31:0]          prdata;
  logic [31:0]          rdata;
  logic                 pready;
  logic                 pslverr;
  logic                 perr;
  hsd_pkg::pins_t       pins        = '0;
  logic [1:0]           sw_on;
  logic                 oe;
  hsd_pkg::sense_mode_t mode;
  hsd_pkg::sense_mode_t adc_mode;
  logic [15:0]          val;
  logic [15:0]          adc;
  logic [5:0]           ctrl        = 6'h00;
  int                   error_cnt   = 0;
  int                   check_count = 0;

  // Free-running core clock, 8 ns
  always #4 i_core_clk = ~i_core_clk;

  hsd_fault_mux dut (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .i_pstrb(4'hf), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_pins(pins), .o_sw_on(sw_on), .o_sense_oe(oe), .o_sense_mode(mode),
    .o_sense_val(val));

  host_adc host (.i_core_clk(i_core_clk), .i_sense_oe(oe), .i_sense_mode(mode),
    .i_sense_val(val), .o_adc(adc), .o_mode(adc_mode));

  // ==========================================================================
  // Checking and bus tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Starts one edge late so no strobe is assigned twice in one time step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge i_core_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge i_core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      give_verdict();
    end
    rdata = prdata;
    perr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic setc(input logic [5:0] c);
    ctrl = c;
    apb(1'b1, hsd_pkg::ADDR_CTRL, {26'h0, c});
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask

  // ==========================================================================
  // Reference model of the sense mux, integer arithmetic
  function automatic logic [17:0] model(input logic [1:0] flt);
    int t;
    if (!ctrl[2] || ctrl[5:4] == 2'b11) return {hsd_pkg::SENSE_HIZ, 16'h0000};
    if (ctrl[4]) begin
      t = $signed(pins.tj_c[0]);
      if ($signed(pins.tj_c[1]) > t) t = $signed(pins.tj_c[1]);
      t = (t - hsd_pkg::TEMP_REF_C) * hsd_pkg::TEMP_SLOPE_UA + hsd_pkg::TEMP_OFFS_UA;
      if (t < 0) t = 0;
      return {hsd_pkg::SENSE_TEMP, 16'(t)};
    end
    if (flt[ctrl[5]]) return {hsd_pkg::SENSE_FAULT, hsd_pkg::FAULT_LVL_UA};
    return {hsd_pkg::SENSE_LOAD,
            16'((longint'(pins.iout_ma[ctrl[5]]) * hsd_pkg::SENSE_RECIP) >> 16)};
  endfunction

  task automatic sense_chk(input logic [1:0] flt);
    logic [17:0] e;
    e = model(flt);
    chk({30'h0, adc_mode}, {30'h0, e[17:16]});
    chk({16'h0, adc}, {16'h0, e[15:0]});
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(25));
    repeat (6) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    // Register reset values, refusals, retry shortening
    apb(1'b0, hsd_pkg::ADDR_CTRL, 32'h0);
    chk(rdata, 32'h0);
    apb(1'b0, hsd_pkg::ADDR_RETRY, 32'h0);
    chk(rdata, 32'h3e8);
    apb(1'b1, 8'h10, 32'h1);
    chk({31'h0, perr}, 32'h1);
    apb(1'b1, hsd_pkg::ADDR_STAT, 32'h1);
    chk({31'h0, perr}, 32'h1);
    apb(1'b1, hsd_pkg::ADDR_RETRY, 32'h4);
    apb(1'b0, hsd_pkg::ADDR_RETRY, 32'h0);
    chk(rdata, 32'h4);
    $display("test registers done");
    // Every select code, diag on and off, random currents and temperatures
    pins.vout_up <= 2'b11;
    for (int i = 0; i < 12; i++) begin
      pins.iout_ma[0] <= 16'($urandom);
      pins.iout_ma[1] <= 16'($urandom);
      pins.tj_c[0]    <= 8'($urandom);
      pins.tj_c[1]    <= 8'($urandom);
      setc({i[1:0], 1'b0, i < 8, 2'b11});
      settle(8);
      sense_chk(2'b00);
    end
    $display("test sense mux done");
    // Latched current-limit shutdown, then retry held by a low output
    setc(6'h0f);
    pins.ilim[0] <= 1'b1;
    settle(8);
    chk({30'h0, sw_on}, 32'h2);
    sense_chk(2'b01);
    pins.ilim[0]    <= 1'b0;
    pins.vout_up[0] <= 1'b0;
    settle(20);
    chk({30'h0, sw_on}, 32'h2);
    setc(6'h07);
    settle(8);
    chk({30'h0, sw_on}, 32'h3);
    settle(40);
    sense_chk(2'b01);
    pins.vout_up[0] <= 1'b1;
    settle(8);
    sense_chk(2'b00);
    // Thermal shutdown on channel two with auto retry
    setc(6'h27);
    pins.tsd[1] <= 1'b1;
    settle(8);
    chk({30'h0, sw_on}, 32'h1);
    sense_chk(2'b10);
    pins.tsd[1] <= 1'b0;
    settle(20);
    chk({30'h0, sw_on}, 32'h3);
    sense_chk(2'b00);
    $display("test fault retry done");
    // Off-state diagnosis of channel two
    pins.iout_ma <= '0;
    pins.vout_ol <= 2'b10;
    setc(6'h24);
    settle(8);
    sense_chk(2'b10);
    setc(6'h04);
    settle(8);
    sense_chk(2'b00);
    setc(6'h24);
    pins.vout_ol[1] <= 1'b0;
    settle(8);
    sense_chk(2'b00);
    pins.vout_ol[1] <= 1'b1;
    settle(8);
    sense_chk(2'b10);
    setc(6'h26);
    settle(8);
    sense_chk(2'b00);
    $display("test off-state diagnosis done");
    // Reverse battery forces both switches on and masks thermal shutdown;
    // the sense line on channel one shows whether a fault was wrongly taken
    setc(6'h04);
    pins.rev_batt <= 1'b1;
    pins.tsd      <= 2'b11;
    settle(8);
    chk({30'h0, sw_on}, 32'h3);
    sense_chk(2'b00);
    pins.rev_batt <= 1'b0;
    pins.tsd      <= 2'b00;
    settle(8);
    chk({30'h0, sw_on}, 32'h0);
    $display("test reverse battery done");
    give_verdict();
  end
endmodule
